// ---- common/ppp_cfg.svh ----
// constants for the program-memory programming controller
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
`define PPP_WORD_W 10
`define PPP_HALF_W 5
`define PPP_BYTE_W 8
`define PPP_WADDR_W 14
`define PPP_BADDR_W 15
`define PPP_UNUSED_BYTE 8'hff
`define PPP_ERASED_WORD 10'h3ff
`define PPP_SETUP_NS 100
`define PPP_PULSE_NS 1000
`define PPP_READ_NS 200
`define PPP_CLK_NS 20
`define PPP_SYNC_CYC 4
`define PPP_SETUP_CYC ((`PPP_SETUP_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_PULSE_CYC ((`PPP_PULSE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_READ_CYC ((`PPP_READ_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`endif

// ---- common/ppp_pkg.sv ----
// types for the program-memory programming controller
package ppp_pkg;
  typedef enum logic [3:0] {
    PPP_IDLE,
    PPP_SETUP,
    PPP_DRIVE,
    PPP_PULSE,
    PPP_HOLD,
    PPP_RD_SETUP,
    PPP_RD_WAIT,
    PPP_NEXT,
    PPP_DONE
  } ppp_state_e;
  typedef enum logic [1:0] {
    PPP_OP_PROGRAM,
    PPP_OP_VERIFY,
    PPP_OP_READ
  } ppp_op_e;
endpackage

// ---- core/ppp_sync.sv ----
// three-stage input synchroniser with agree filter for pin inputs
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_sync #(
  parameter int W = 8
) (
  sys_clk,
  rst_n,
  din,
  dout
);
  input wire logic sys_clk;
  input wire logic rst_n;
  input wire logic [W-1:0] din;
  output logic [W-1:0] dout;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  wire [W-1:0] agree = ~(s2_r ^ s3_r);

  // ----------------------------------------
  // per-bit stages
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r[i] <= 1'b1;
          s2_r[i] <= 1'b1;
          s3_r[i] <= 1'b1;
          dout[i] <= 1'b1;
        end
        else
        begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (agree[i])
            dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

// ---- core/ppp_host.sv ----
// programmer-side controller that writes and verifies ten-bit words over the byte-wide port
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_host #(
  parameter int SETUP_CYC = `PPP_SETUP_CYC,
  parameter int PULSE_CYC = `PPP_PULSE_CYC,
  parameter int READ_CYC = `PPP_READ_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [`PPP_WADDR_W-1:0] req_addr,
  input wire logic [`PPP_WORD_W-1:0] req_word,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`PPP_WORD_W-1:0] rsp_word,
  output logic rsp_mismatch,
  output logic prog_mode_active,
  output logic factory_check_n,
  output logic mode_select_zero_n,
  output logic mode_select_one_n,
  output logic dev_reset,
  output logic vpp_on,
  output logic [`PPP_BADDR_W-1:0] byte_addr,
  output logic chip_select_n,
  output logic output_drive_n,
  output logic [`PPP_BYTE_W-1:0] byte_data_lines_o,
  output logic byte_data_lines_oe,
  input wire logic [`PPP_BYTE_W-1:0] byte_data_lines_i
);
  logic [`PPP_BYTE_W-1:0] rd_sync;
  ppp_sync #(
    .W(`PPP_BYTE_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(byte_data_lines_i),
    .dout(rd_sync)
  );

  ppp_pkg::ppp_state_e state_r;
  ppp_pkg::ppp_state_e state_nxt;
  ppp_pkg::ppp_op_e op_r;
  logic [`PPP_WORD_W-1:0] word_r;
  logic [`PPP_WADDR_W-1:0] waddr_r;
  logic half_r;
  logic [`PPP_HALF_W-1:0] lo_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire is_prog = (op_r == ppp_pkg::PPP_OP_PROGRAM);
  // req_ready is low in the first cycle after reset although the sequencer already idles
  wire take = req_valid && req_ready;
  wire cnt_done = (cnt_r == 16'h0000);
  wire [`PPP_HALF_W-1:0] half_sel = half_r ? word_r[`PPP_WORD_W-1:`PPP_HALF_W] : word_r[`PPP_HALF_W-1:0];
  // unused upper bits driven high so blank bytes stay all ones
  wire [`PPP_BYTE_W-1:0] wr_byte = {{(`PPP_BYTE_W-`PPP_HALF_W){1'b1}}, half_sel};
  wire [`PPP_BADDR_W-1:0] baddr = {waddr_r, half_r};
  wire [`PPP_HALF_W-1:0] rd_half = rd_sync[`PPP_HALF_W-1:0];
  wire [`PPP_WORD_W-1:0] rd_word = {rd_half, lo_r};
  wire [15:0] setup_c = 16'(SETUP_CYC - 1);
  wire [15:0] pulse_c = 16'(PULSE_CYC - 1);
  wire [15:0] read_c = 16'(READ_CYC - 1);
  // read data crosses the pin synchroniser, so the sample waits out its depth
  wire [15:0] sync_c = 16'(`PPP_SYNC_CYC);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 16'h0001;
    case (state_r)
      ppp_pkg::PPP_IDLE:
        if (take)
        begin
          state_nxt = ppp_pkg::PPP_SETUP;
          cnt_nxt = setup_c;
        end
      ppp_pkg::PPP_SETUP:
        if (cnt_done)
        begin
          state_nxt = is_prog ? ppp_pkg::PPP_DRIVE : ppp_pkg::PPP_RD_SETUP;
          cnt_nxt = is_prog ? setup_c : read_c;
        end
      ppp_pkg::PPP_DRIVE:
        if (cnt_done)
        begin
          state_nxt = ppp_pkg::PPP_PULSE;
          cnt_nxt = pulse_c;
        end
      ppp_pkg::PPP_PULSE:
        if (cnt_done)
        begin
          state_nxt = ppp_pkg::PPP_HOLD;
          cnt_nxt = setup_c;
        end
      ppp_pkg::PPP_HOLD:
        if (cnt_done)
          state_nxt = ppp_pkg::PPP_NEXT;
      ppp_pkg::PPP_RD_SETUP:
        if (cnt_done)
        begin
          state_nxt = ppp_pkg::PPP_RD_WAIT;
          cnt_nxt = setup_c + sync_c;
        end
      ppp_pkg::PPP_RD_WAIT:
        if (cnt_done)
          state_nxt = ppp_pkg::PPP_NEXT;
      ppp_pkg::PPP_NEXT:
        if (half_r)
        begin
          // only a finished program pass goes on to reread; verify and read end here
          state_nxt = is_prog ? ppp_pkg::PPP_RD_SETUP : ppp_pkg::PPP_DONE;
          cnt_nxt = read_c;
        end
        else
        begin
          state_nxt = ppp_pkg::PPP_SETUP;
          cnt_nxt = setup_c;
        end
      ppp_pkg::PPP_DONE:
        state_nxt = ppp_pkg::PPP_IDLE;
      default:
        state_nxt = ppp_pkg::PPP_IDLE;
    endcase
  end

  logic verify_pass_r;
  wire in_read = (state_r == ppp_pkg::PPP_RD_SETUP) || (state_r == ppp_pkg::PPP_RD_WAIT);
  wire in_drive = (state_r == ppp_pkg::PPP_DRIVE) || (state_r == ppp_pkg::PPP_PULSE) || (state_r == ppp_pkg::PPP_HOLD);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ppp_pkg::PPP_IDLE;
      cnt_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // request capture and half stepping
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_r <= ppp_pkg::PPP_OP_READ;
      word_r <= `PPP_ERASED_WORD;
      waddr_r <= '0;
      half_r <= 1'b0;
      lo_r <= '0;
      verify_pass_r <= 1'b0;
    end
    else if (state_r == ppp_pkg::PPP_IDLE && take)
    begin
      op_r <= ppp_pkg::ppp_op_e'(req_op);
      word_r <= req_word;
      waddr_r <= req_addr;
      half_r <= 1'b0;
      verify_pass_r <= 1'b0;
    end
    else if (state_r == ppp_pkg::PPP_NEXT)
    begin
      // after a program pass, a verify pass rereads both halves
      if (half_r && is_prog)
        op_r <= ppp_pkg::PPP_OP_VERIFY;
      half_r <= ~half_r;
      verify_pass_r <= half_r && is_prog;
    end
    else if (state_r == ppp_pkg::PPP_RD_WAIT && cnt_done && !half_r)
      lo_r <= rd_half;
  end

  // ----------------------------------------
  // pin drive, all from flip-flops
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      factory_check_n <= 1'b1;
      mode_select_zero_n <= 1'b1;
      mode_select_one_n <= 1'b1;
      dev_reset <= 1'b0;
      vpp_on <= 1'b0;
      byte_addr <= '0;
      chip_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      byte_data_lines_o <= `PPP_UNUSED_BYTE;
      byte_data_lines_oe <= 1'b0;
      prog_mode_active <= 1'b0;
    end
    else
    begin
      factory_check_n <= 1'b0;
      mode_select_zero_n <= 1'b0;
      mode_select_one_n <= 1'b0;
      dev_reset <= 1'b1;
      prog_mode_active <= 1'b1;
      vpp_on <= (state_r != ppp_pkg::PPP_IDLE);
      byte_addr <= baddr;
      chip_select_n <= !(state_r == ppp_pkg::PPP_PULSE);
      output_drive_n <= !in_read;
      byte_data_lines_o <= wr_byte;
      byte_data_lines_oe <= in_drive && is_prog;
    end
  end

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= `PPP_ERASED_WORD;
      rsp_mismatch <= 1'b0;
    end
    else
    begin
      req_ready <= (state_nxt == ppp_pkg::PPP_IDLE);
      rsp_valid <= 1'b0;
      if (state_r == ppp_pkg::PPP_RD_WAIT && cnt_done && half_r)
      begin
        rsp_valid <= 1'b1;
        rsp_word <= rd_word;
        rsp_mismatch <= (op_r == ppp_pkg::PPP_OP_VERIFY) && (rd_word != word_r);
      end
    end
  end
endmodule

// ---- tb/ppp_host_monitor.sv ----
// port checker for the programming controller
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_host_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic prog_mode_active,
  input wire logic factory_check_n,
  input wire logic mode_select_zero_n,
  input wire logic mode_select_one_n,
  input wire logic dev_reset,
  input wire logic vpp_on,
  input wire logic [`PPP_BADDR_W-1:0] byte_addr,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic [`PPP_BYTE_W-1:0] byte_data_lines_o,
  input wire logic byte_data_lines_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_burn;
    !chip_select_n ##1 !chip_select_n;
  endsequence
  a_mode_pins: assert property (prog_mode_active |-> !factory_check_n && !mode_select_zero_n
    && !mode_select_one_n && dev_reset) else $error("mode pins wrong");
  a_burn_decode: assert property (!chip_select_n |-> output_drive_n && vpp_on && byte_data_lines_oe)
    else $error("program decode wrong");
  a_read_decode: assert property (!output_drive_n |-> chip_select_n && vpp_on && !byte_data_lines_oe)
    else $error("verify decode wrong");
  a_burn_steady: assert property (s_burn |-> $stable(byte_addr) && $stable(byte_data_lines_o))
    else $error("pulse inputs moved");
  a_pad_ones: assert property (byte_data_lines_oe |-> byte_data_lines_o[7:5] == 3'b111)
    else $error("pad bits not ones");
  a_idle_inhibit: assert property (req_ready |-> chip_select_n && output_drive_n)
    else $error("idle not inhibited");
  a_answer_idle: assert property (rsp_valid |-> ##[1:3] req_ready)
    else $error("no idle after answer");
endmodule
bind ppp_host ppp_host_monitor u_mon (.sys_clk, .rst_n, .req_ready, .rsp_valid, .prog_mode_active,
  .factory_check_n, .mode_select_zero_n, .mode_select_one_n, .dev_reset, .vpp_on, .byte_addr,
  .chip_select_n, .output_drive_n, .byte_data_lines_o, .byte_data_lines_oe);

// ---- tb/ppp_prom_model.sv ----
// device-side model of the program memory in programming mode
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_prom_model (
  input wire logic factory_check_n,
  input wire logic mode_select_zero_n,
  input wire logic mode_select_one_n,
  input wire logic dev_reset,
  input wire logic vpp_on,
  input wire logic [`PPP_BADDR_W-1:0] byte_addr,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic [`PPP_BYTE_W-1:0] host_d,
  input wire logic host_oe,
  output logic [`PPP_BYTE_W-1:0] pin_d
);
  logic [`PPP_HALF_W-1:0] mem [0:(1<<`PPP_BADDR_W)-1];
  logic [`PPP_BYTE_W-1:0] held = 8'h5a;
  wire prom = !factory_check_n && !mode_select_zero_n && !mode_select_one_n && dev_reset;
  wire rd = prom && vpp_on && chip_select_n && !output_drive_n;
  wire [`PPP_BYTE_W-1:0] drv = host_oe ? host_d : {3'b111, mem[byte_addr]};
  // released lines show the inverse so a stale value cannot pass
  assign pin_d = (host_oe || rd) ? drv : ~held;
  initial
  begin
    for (int i = 0; i < (1<<`PPP_BADDR_W); i++)
      mem[i] = 5'h1f;
  end
  always @(drv, host_oe, rd)
    if (host_oe || rd)
      held = drv;
  // programming can only clear bits
  always @(posedge chip_select_n)
    if (prom && vpp_on && output_drive_n)
      mem[byte_addr] = mem[byte_addr] & host_d[4:0];
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the programming controller against the memory model
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module testbench;
  logic sys_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_mismatch, fc_n, m0_n, m1_n, dres, vpp, cs_n, od_n, hoe;
  logic [1:0] req_op;
  logic [13:0] req_addr;
  logic [9:0] req_word, rsp_word;
  logic [14:0] baddr;
  logic [7:0] hd, pin;
  int fails = 0;
  int cmp_count = 0;
  typedef struct {logic [1:0] op; logic [13:0] a; logic [9:0] w; logic [9:0] ew; logic em;} ppp_row_s;
  ppp_row_s rows [7] = '{'{2'h0, 14'h3fff, 10'h155, 10'h155, 1'b0}, '{2'h0, 14'h0, 10'h3ff, 10'h3ff, 1'b0},
    '{2'h2, 14'h3fff, 10'h0, 10'h155, 1'b0}, '{2'h1, 14'h3fff, 10'h2aa, 10'h155, 1'b1},
    '{2'h2, 14'h5, 10'h0, 10'h3ff, 1'b0}, '{2'h0, 14'h1, 10'h0, 10'h0, 1'b0}, '{2'h1, 14'h1, 10'h0, 10'h0, 1'b0}};
  ppp_host #(.SETUP_CYC(1), .PULSE_CYC(2), .READ_CYC(1)) u_ppp_host (.sys_clk, .rst_n, .req_valid, .req_op,
    .req_addr, .req_word, .req_ready, .rsp_valid, .rsp_word, .rsp_mismatch, .prog_mode_active(),
    .factory_check_n(fc_n), .mode_select_zero_n(m0_n), .mode_select_one_n(m1_n), .dev_reset(dres),
    .vpp_on(vpp), .byte_addr(baddr), .chip_select_n(cs_n), .output_drive_n(od_n), .byte_data_lines_o(hd),
    .byte_data_lines_oe(hoe), .byte_data_lines_i(pin));
  ppp_prom_model u_ppp_prom_model (.factory_check_n(fc_n), .mode_select_zero_n(m0_n), .mode_select_one_n(m1_n),
    .dev_reset(dres), .vpp_on(vpp), .byte_addr(baddr), .chip_select_n(cs_n), .output_drive_n(od_n),
    .host_d(hd), .host_oe(hoe), .pin_d(pin));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("compared %0d mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [14:0] s, input logic [14:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic req(input logic [1:0] op, input logic [13:0] a, input logic [9:0] w);
    int n;
    n = 0;
    req_op = op;
    req_addr = a;
    req_word = w;
    req_valid = 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 400);
    #1 req_valid = 1'b0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      fails++;
      summarize();
    end
    #1;
  endtask
  initial
  begin
    {rst_n, req_valid, req_op, req_addr, req_word} = '0;
    repeat (5) @(posedge sys_clk);
    check(rsp_word, 15'h3ff);
    check(fc_n, 15'h1);
    #1 rst_n = 1'b1;
    foreach (rows[i])
    begin
      req(rows[i].op, rows[i].a, rows[i].w);
      check(rsp_word, rows[i].ew);
      check(rsp_mismatch, rows[i].em);
      $display("test %0d done", i);
    end
    check(u_ppp_prom_model.mem[15'h7ffe], 15'h15);
    check(u_ppp_prom_model.mem[15'h7fff], 15'h0a);
    // abort a program in mid-pulse
    req_op = 2'h0;
    req_addr = 14'h2;
    req_valid = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b0;
    req_valid = 1'b0;
    #1 check(fc_n, 15'h1);
    check(req_ready, 15'h0);
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    req(2'h2, 14'h3fff, 10'h0);
    check(rsp_word, 15'h155);
    $display("test reset done");
    summarize();
  end
endmodule
